// file: logic/dts_cfg.svh
// Constants for the dual thread sequencer: offsets, positions, resets and counts.
`ifndef DTS_CFG_SVH
`define DTS_CFG_SVH
// ---------------------------------------------------------------------------
// Register offsets on the software port.
// ---------------------------------------------------------------------------
`define DTS_OFF_SP 8'h02
`define DTS_OFF_ENABLE 8'h10
`define DTS_OFF_STATUS 8'h11
`define DTS_OFF_OPTION 8'h12
// ---------------------------------------------------------------------------
// Field positions and reset values.
// ---------------------------------------------------------------------------
`define DTS_EN_T0_BIT 0
`define DTS_EN_T1_BIT 1
`define DTS_EN_RESET 2'h1
`define DTS_IP0_RESET 12'h000
`define DTS_IP1_RESET 12'h001
`define DTS_IRQ_ENTRY 12'h010
`define DTS_SP_RESET 8'h00
`define DTS_SRAM_BYTES 9'h0d0
// ---------------------------------------------------------------------------
// Timing: the boot wait in slow oscillator periods.
// ---------------------------------------------------------------------------
`define DTS_BOOT_SLOW_CYCLES 1024
`endif

// file: logic/dts_pkg.sv
// Types shared by the dual thread sequencer files.
package dts_pkg;
  // Operation requested by the executing instruction.
  typedef enum logic [1:0] {
    DTS_OP_SEQ = 2'h0,
    DTS_OP_JUMP = 2'h1,
    DTS_OP_CALL = 2'h2,
    DTS_OP_RET = 2'h3
  } dts_op_t;
  // Boot states, one-hot.
  typedef enum logic [1:0] {
    DTS_BOOT_WAIT = 2'b01,
    DTS_BOOT_RUN = 2'b10
  } dts_boot_t;
endpackage

// file: logic/dts_sync.sv
// Two flip-flop synchroniser for one level from outside the clock domain.
module dts_sync (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic sync_o
);
  // First stage, read only by the second stage.
  logic meta;
  // ---------------------------------------------------------------------------
  // Synchroniser chain.
  // ---------------------------------------------------------------------------
  // Both stages clear to zero so nothing unknown leaves during reset.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule

// file: logic/dts_thread_ctx.sv
// Private context of one thread: instruction pointer, stack pointer, acc, flags.
`include "dts_cfg.svh"
module dts_thread_ctx #(
  parameter logic [11:0] IP_RESET = 12'h000
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic step_i,
  input wire dts_pkg::dts_op_t op_i,
  input wire logic [11:0] target_i,
  input wire logic irq_i,
  input wire logic sp_we_i,
  input wire logic [7:0] sp_wdata_i,
  input wire logic acc_we_i,
  input wire logic [7:0] acc_wdata_i,
  input wire logic flag_we_i,
  input wire logic [3:0] flag_wdata_i,
  output logic [11:0] ip_o,
  output logic [7:0] sp_o,
  output logic [7:0] acc_o,
  output logic [3:0] flag_o
);
  // Next instruction pointer chosen from the operation.
  logic [11:0] next_ip;
  // Sequential step with twelve-bit wrap.
  wire [11:0] seq_ip = ip_o + 12'h001;
  // ---------------------------------------------------------------------------
  // Pointer selection.
  // ---------------------------------------------------------------------------
  // Interrupt entry wins over the fetched operation; the entry only reaches thread 0.
  assign next_ip = irq_i ? `DTS_IRQ_ENTRY :
                   (op_i == dts_pkg::DTS_OP_SEQ) ? seq_ip : target_i;
  // ---------------------------------------------------------------------------
  // Context registers, changed on this thread's own steps or by a stack pointer write.
  // ---------------------------------------------------------------------------
  // Nothing moves without step_i, so a disabled thread keeps its state.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ip_o <= IP_RESET;
      acc_o <= 8'h00;
      flag_o <= 4'h0;
    end else if (step_i) begin
      ip_o <= next_ip;
      if (acc_we_i) begin
        acc_o <= acc_wdata_i;
      end
      if (flag_we_i) begin
        flag_o <= flag_wdata_i;
      end
    end
  end
  // Stack pointer: software write or push/pop of a two-byte return address.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sp_o <= `DTS_SP_RESET;
    end else if (sp_we_i) begin
      sp_o <= sp_wdata_i;
    end else if (step_i && !irq_i && op_i == dts_pkg::DTS_OP_CALL) begin
      sp_o <= sp_o + 8'h02;
    end else if (step_i && !irq_i && op_i == dts_pkg::DTS_OP_RET) begin
      sp_o <= sp_o - 8'h02;
    end
  end
endmodule

// file: logic/dts_sequencer.sv
// Top of the dual thread sequencer: task switch, enables, boot wait, registers.
`include "dts_cfg.svh"
// Operation
// [RQ1] Threads own alternate, exclusive system cycles.
// [RQ2] Each thread steps every second cycle.
// [RQ3] After reset only thread 0 runs.
// [RQ4] Either thread may enable or disable either.
// [RQ5] Pointer advances by one per own cycle.
// [RQ6] Branch or call loads a new target.
// [RQ7] Instruction pointers are twelve bits wide.
// [RQ8] Reset pointers: thread 0 zero, thread 1 one.
// [RQ9] Interrupt sends thread 0 only to 0x10.
// [RQ10] Each thread keeps private pointer, accumulator, flags.
// [RQ11] Both threads share program, data and IO.
// [RQ12] IO address 0x02 selects accessor's stack pointer.
// [RQ13] Stack pointer is eight bits, addresses SRAM.
// [RQ14] Software keeps stacks within 208 SRAM bytes.
// [RQ15] Stack pointer saves and restores return address.
// [RQ16] Single-thread option keeps thread 1 off.
// [RQ17] Wait 1024 slow oscillator cycles after reset.
// [RQ18] Disabled thread's cycle executes nothing, holds state.
module dts_sequencer (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic slow_osc_i,
  input wire logic single_thread_i,
  input wire logic irq_i,
  input wire dts_pkg::dts_op_t op_i,
  input wire logic [11:0] target_i,
  input wire logic acc_we_i,
  input wire logic [7:0] acc_wdata_i,
  input wire logic flag_we_i,
  input wire logic [3:0] flag_wdata_i,
  input wire logic io_we_i,
  input wire logic [7:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  output logic [11:0] fetch_addr_o,
  output logic fetch_valid_o,
  output logic owner_o,
  output logic [7:0] stack_addr_o,
  output logic stack_valid_o,
  output logic [7:0] acc_o,
  output logic [3:0] flag_o,
  output logic booted_o
);
  // ---------------------------------------------------------------------------
  // Boot wait on the slow oscillator.
  // ---------------------------------------------------------------------------
  // Synchronised oscillator level and its previous value for edge detection.
  logic osc_sync;
  logic osc_prev;
  // Counter of slow oscillator rising edges seen since reset.
  logic [10:0] boot_count;
  // Boot state, one-hot.
  dts_pkg::dts_boot_t boot_state;
  dts_pkg::dts_boot_t next_boot_state;
  // One-cycle pulse for each slow oscillator rising edge.
  wire osc_rise = osc_sync && !osc_prev;
  // The count reaches the full boot wait.
  wire boot_done = (boot_count == 11'(`DTS_BOOT_SLOW_CYCLES));

  // The oscillator is asynchronous to the system clock, so it is synchronised.
  dts_sync u_osc_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .async_i(slow_osc_i),
    .sync_o(osc_sync)
  );

  // Edge history and edge counter; the counter stops at the full wait.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_prev <= 1'b0;
      boot_count <= 11'h000;
    end else begin
      osc_prev <= osc_sync;
      if (osc_rise && !boot_done) begin
        boot_count <= boot_count + 11'h001; // RQ17
      end
    end
  end

  // Boot state chooser: wait until the count completes, then run forever.
  always_comb begin
    next_boot_state = boot_state;
    unique case (boot_state)
      dts_pkg::DTS_BOOT_WAIT: begin
        if (boot_done) begin
          next_boot_state = dts_pkg::DTS_BOOT_RUN; // RQ17
        end
      end
      dts_pkg::DTS_BOOT_RUN: begin
        next_boot_state = dts_pkg::DTS_BOOT_RUN;
      end
      default: begin
        next_boot_state = dts_pkg::DTS_BOOT_WAIT;
      end
    endcase
  end

  // Boot state register.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_state <= dts_pkg::DTS_BOOT_WAIT;
    end else begin
      boot_state <= next_boot_state;
    end
  end

  // Execution may begin only once the boot wait is over.
  wire running = (boot_state == dts_pkg::DTS_BOOT_RUN);
  assign booted_o = running;

  // ---------------------------------------------------------------------------
  // Task switch and thread enables.
  // ---------------------------------------------------------------------------
  // Cycle owner: toggles every running cycle, giving each thread every second cycle.
  logic owner;
  // Thread enable register, bit 0 thread 0, bit 1 thread 1.
  logic [1:0] enable;
  // Single-thread option, caught in a clocked process after reset release.
  logic single_mode;
  // Option level after two flip-flops; the strap pin is not timed to this clock.
  logic single_sync;

  // The strap may settle late after power-up, so it passes the synchroniser first.
  dts_sync u_single_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .async_i(single_thread_i),
    .sync_o(single_sync)
  );

  // Strap capture before boot ends; its value settles three cycles after release.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      single_mode <= 1'b0;
    end else if (!running) begin
      single_mode <= single_sync;
    end
  end

  // Ownership alternates only while running, so thread 0 owns the first cycle.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      owner <= 1'b0;
    end else if (running) begin
      owner <= ~owner; // RQ1 RQ2
    end
  end
  assign owner_o = owner;

  // Enabled state of the thread owning this cycle; single mode forces thread 1 off.
  wire owner_enabled = owner ? (enable[`DTS_EN_T1_BIT] && !single_mode) :
                               enable[`DTS_EN_T0_BIT]; // RQ16
  // An instruction executes only in a running cycle whose owner is enabled.
  wire exec = running && owner_enabled; // RQ18
  // Step strobes per thread; at most one thread can step in a cycle.
  wire step0 = exec && !owner; // RQ1
  wire step1 = exec && owner; // RQ1

  // Writes from the executing thread land on the shared IO space.
  wire io_write = exec && io_we_i;
  // Software port write of the same register.
  wire sw_en_write = reg_we_i && (reg_addr_i == `DTS_OFF_ENABLE);
  // Either thread writes the enable register through IO.
  wire io_en_write = io_write && (io_addr_i == `DTS_OFF_ENABLE);

  // Enable register: any executing thread may change both bits, itself included.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable <= `DTS_EN_RESET; // RQ3
    end else if (io_en_write) begin
      enable <= io_wdata_i[1:0]; // RQ4
    end else if (sw_en_write) begin
      enable <= reg_wdata_i[1:0]; // RQ4
    end
  end

  // ---------------------------------------------------------------------------
  // Stack pointer access at IO address 0x02.
  // ---------------------------------------------------------------------------
  // IO write at the stack pointer address selects the accessor's own copy.
  wire io_sp_write = io_write && (io_addr_i == `DTS_OFF_SP); // RQ12
  // Software port writes go to the copy of the thread owning the cycle.
  wire sw_sp_write = reg_we_i && (reg_addr_i == `DTS_OFF_SP);
  wire [7:0] sp_wdata = io_sp_write ? io_wdata_i : reg_wdata_i;
  wire sp_we0 = (io_sp_write && !owner) || (sw_sp_write && !io_sp_write && !owner);
  wire sp_we1 = (io_sp_write && owner) || (sw_sp_write && !io_sp_write && owner);

  // ---------------------------------------------------------------------------
  // Per-thread contexts.
  // ---------------------------------------------------------------------------
  logic [11:0] ip0;
  logic [11:0] ip1;
  logic [7:0] sp0;
  logic [7:0] sp1;
  logic [7:0] acc0;
  logic [7:0] acc1;
  logic [3:0] flag0;
  logic [3:0] flag1;
  // Interrupt entry is offered to thread 0 only.
  wire irq0 = irq_i; // RQ9

  // Thread 0 context, reset pointer zero, the only one with interrupt entry.
  dts_thread_ctx #(
    .IP_RESET(`DTS_IP0_RESET)
  ) u_ctx0 (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .step_i(step0),
    .op_i(op_i),
    .target_i(target_i),
    .irq_i(irq0),
    .sp_we_i(sp_we0),
    .sp_wdata_i(sp_wdata),
    .acc_we_i(acc_we_i),
    .acc_wdata_i(acc_wdata_i),
    .flag_we_i(flag_we_i),
    .flag_wdata_i(flag_wdata_i),
    .ip_o(ip0),
    .sp_o(sp0),
    .acc_o(acc0),
    .flag_o(flag0)
  ); // RQ5 RQ6 RQ7 RQ8 RQ10 RQ15

  // Thread 1 context, reset pointer one, never takes the interrupt.
  dts_thread_ctx #(
    .IP_RESET(`DTS_IP1_RESET)
  ) u_ctx1 (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .step_i(step1),
    .op_i(op_i),
    .target_i(target_i),
    .irq_i(1'b0),
    .sp_we_i(sp_we1),
    .sp_wdata_i(sp_wdata),
    .acc_we_i(acc_we_i),
    .acc_wdata_i(acc_wdata_i),
    .flag_we_i(flag_we_i),
    .flag_wdata_i(flag_wdata_i),
    .ip_o(ip1),
    .sp_o(sp1),
    .acc_o(acc1),
    .flag_o(flag1)
  ); // RQ8 RQ9 RQ10

  // ---------------------------------------------------------------------------
  // Shared resource port driven by the owner of the cycle.
  // ---------------------------------------------------------------------------
  // One fetch address per cycle toward the common program memory.
  assign fetch_addr_o = owner ? ip1 : ip0; // RQ11
  assign fetch_valid_o = exec;
  // Stack address into SRAM: pop reads below, push writes at the pointer.
  wire [7:0] owner_sp = owner ? sp1 : sp0;
  assign stack_addr_o = (op_i == dts_pkg::DTS_OP_RET) ? owner_sp - 8'h02 : owner_sp; // RQ13
  // Software is expected to keep stacks within the SRAM; no bound check here.
  assign stack_valid_o = exec && !(owner == 1'b0 && irq_i) &&
                         (op_i == dts_pkg::DTS_OP_CALL || op_i == dts_pkg::DTS_OP_RET); // RQ15
  assign acc_o = owner ? acc1 : acc0; // RQ10
  assign flag_o = owner ? flag1 : flag0;

  // ---------------------------------------------------------------------------
  // Software read port: data one cycle after the strobe.
  // ---------------------------------------------------------------------------
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr_i == `DTS_OFF_SP) begin
      next_rdata = owner_sp;
    end else if (reg_addr_i == `DTS_OFF_ENABLE) begin
      next_rdata = {6'h00, enable};
    end else if (reg_addr_i == `DTS_OFF_STATUS) begin
      next_rdata = {5'h00, owner, running, exec};
    end else if (reg_addr_i == `DTS_OFF_OPTION) begin
      next_rdata = {7'h00, single_mode};
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_re_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------------
  owner_alt_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ1
    running |=> owner != $past(owner)) else $error("owner did not alternate");

  step_excl_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ1
    !(step0 && step1)) else $error("both threads stepped");

  step_gap_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ2
    step0 |=> !step0) else $error("thread 0 stepped twice in a row");

  seq_ip_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ5
    step1 && op_i == dts_pkg::DTS_OP_SEQ |=> ip1 == $past(ip1) + 12'h001)
    else $error("thread 1 pointer not incremented");

  jump_ip_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ6
    step0 && !irq_i && op_i == dts_pkg::DTS_OP_JUMP |=> ip0 == $past(target_i))
    else $error("thread 0 jump target not loaded");

  irq_entry_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ9
    step0 && irq_i |=> ip0 == `DTS_IRQ_ENTRY) else $error("interrupt entry missed");

  hold_off_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ18
    running && owner && !enable[1] |=> ip1 == $past(ip1) && acc1 == $past(acc1))
    else $error("disabled thread changed");

  single_off_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ16
    single_mode |-> !step1) else $error("thread 1 ran in single mode");

  boot_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ17
    !boot_done |-> !fetch_valid_o) else $error("fetch before boot wait");

  call_push_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ15
    step1 && !sp_we1 && op_i == dts_pkg::DTS_OP_CALL |=> sp1 == $past(sp1) + 8'h02)
    else $error("call did not push");

  ret_pop_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ15
    step0 && !sp_we0 && !irq_i && op_i == dts_pkg::DTS_OP_RET |=> sp0 == $past(sp0) - 8'h02)
    else $error("return did not pop");

  io_sp_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ12
    io_sp_write && !owner |=> sp0 == $past(io_wdata_i))
    else $error("own stack pointer not written by IO");
endmodule

// file: verification/dts_mem_model.sv
// Behavioural model of the shared program memory and the stack area of data SRAM.
module dts_mem_model (
  input wire logic clock_i,
  input wire logic [11:0] fetch_addr_i,
  input wire logic fetch_valid_i,
  input wire logic [7:0] stack_addr_i,
  input wire logic stack_valid_i,
  output dts_pkg::dts_op_t op_o,
  output logic [11:0] target_o,
  output logic acc_we_o,
  output logic [7:0] acc_wdata_o,
  output logic flag_we_o,
  output logic [3:0] flag_wdata_o
);
  // ---------------------------------------------------------------------------
  // Storage shared by both threads.
  // ---------------------------------------------------------------------------
  logic [15:0] rom [0:4095]; // One program store for both threads.
  logic [7:0] sram [0:207]; // Stacks must fit in these bytes.
  logic [15:0] word; // Instruction word at the fetch address.
  logic [11:0] ret_addr; // Return address pushed by a call.

  // Word layout of this model: op, acc write, flag write, target or data.
  initial begin
    for (int i = 0; i < 4096; i++) rom[i] = 16'h0000;
    for (int i = 0; i < 208; i++) sram[i] = 8'h00;
    rom[12'h000] = 16'h4020;
    rom[12'h020] = 16'h305a;
    rom[12'h021] = 16'h8040;
    rom[12'h040] = 16'hc000;
    rom[12'h022] = 16'h4022;
    rom[12'h004] = 16'h8050;
    rom[12'h050] = 16'hc000;
  end

  // Decoded controls are quiet outside executing cycles, so no stray write lands.
  assign word = rom[fetch_addr_i];
  assign ret_addr = fetch_addr_i + 12'h001;
  assign op_o = fetch_valid_i ? dts_pkg::dts_op_t'(word[15:14]) : dts_pkg::DTS_OP_SEQ;
  assign target_o = (op_o == dts_pkg::DTS_OP_RET) ?
    {sram[stack_addr_i + 8'h01][3:0], sram[stack_addr_i]} : word[11:0];
  assign acc_we_o = fetch_valid_i & word[13];
  assign acc_wdata_o = word[7:0];
  assign flag_we_o = fetch_valid_i & word[12];
  assign flag_wdata_o = word[3:0];

  // A call stores its return address low byte first at the stack top.
  always @(posedge clock_i) begin
    if (stack_valid_i && op_o == dts_pkg::DTS_OP_CALL) begin
      sram[stack_addr_i] <= ret_addr[7:0];
      sram[stack_addr_i + 8'h01] <= {4'h0, ret_addr[11:8]};
    end
  end
endmodule

// file: verification/tb_dts_sequencer.sv
// Self-checking bench for the dual thread sequencer beside its memory model.
module tb_dts_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------------------
  // Bench signals; those the bench drives into the design get a value at time zero.
  // ---------------------------------------------------------------------------
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic slow_osc_i = 1'b0;
  logic single_thread_i = 1'b0;
  logic irq_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic io_we_i = 1'b0;
  logic [1:0] div = 2'h0; // Divider that makes the slow oscillator.
  dts_pkg::dts_op_t op;
  logic [11:0] target, fetch_addr_o;
  logic acc_we, flag_we, fetch_valid_o, owner_o, stack_valid_o, booted_o;
  logic [7:0] acc_wdata, reg_rdata_o, stack_addr_o, acc_o;
  logic [3:0] flag_wdata, flag_o;
  logic [11:0] exp_ip [8]; // Expected fetch addresses of the traced thread.
  int bad_count = 0;
  int n_compared = 0;

  // The clock toggles each half period; the slow clock has a four-cycle period.
  always #12.5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    div <= div + 2'h1;
    slow_osc_i <= div[1];
  end

  // IO writes borrow the software port's address and data lines; io_we_i marks them.
  dts_sequencer dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .slow_osc_i(slow_osc_i),
    .single_thread_i(single_thread_i), .irq_i(irq_i), .op_i(op), .target_i(target),
    .acc_we_i(acc_we), .acc_wdata_i(acc_wdata), .flag_we_i(flag_we),
    .flag_wdata_i(flag_wdata), .io_we_i(io_we_i), .io_addr_i(reg_addr_i),
    .io_wdata_i(reg_wdata_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .fetch_addr_o(fetch_addr_o),
    .fetch_valid_o(fetch_valid_o), .owner_o(owner_o), .stack_addr_o(stack_addr_o),
    .stack_valid_o(stack_valid_o), .acc_o(acc_o), .flag_o(flag_o), .booted_o(booted_o));
  dts_mem_model mem (.clock_i(clock_i), .fetch_addr_i(fetch_addr_o),
    .fetch_valid_i(fetch_valid_o), .stack_addr_i(stack_addr_o),
    .stack_valid_i(stack_valid_o), .op_o(op), .target_o(target), .acc_we_o(acc_we),
    .acc_wdata_o(acc_wdata), .flag_we_o(flag_we), .flag_wdata_o(flag_wdata));

  // ---------------------------------------------------------------------------
  // Compare, report and bus tasks.
  // ---------------------------------------------------------------------------
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // A write is one strobe cycle; the next access starts a cycle later.
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clock_i);
    reg_we_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, then fall back to zero.
  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clock_i);
    reg_re_i <= 1'b0;
    @(negedge clock_i);
    check("read data", {4'h0, exp}, {4'h0, reg_rdata_o});
    @(negedge clock_i);
    check("read idle", 12'h000, {4'h0, reg_rdata_o});
  endtask

  // Reset for 12 cycles with the thread option set from single; fetch, owner and boot outputs are checked idle at its end.
  task automatic do_reset(input logic single);
    rst_n_i <= 1'b0;
    single_thread_i <= single;
    repeat (12) @(posedge clock_i);
    check("reset fetch", 12'h000, fetch_addr_o);
    check("reset owner", 12'h000, {9'h000, fetch_valid_o, owner_o, booted_o});
    rst_n_i <= 1'b1;
  endtask

  // Nothing runs until the slow clock has ticked its boot count; bounded wait after.
  task automatic wait_boot();
    int early;
    int w;
    early = 0;
    w = 0;
    repeat (3900) begin
      @(negedge clock_i);
      if (fetch_valid_o !== 1'b0 || booted_o !== 1'b0) early++;
    end
    check("early run", 12'h000, early[11:0]);
    while (booted_o !== 1'b1 && w < 400) begin
      @(negedge clock_i);
      w++;
    end
    check("booted", 12'h001, {11'h000, booted_o});
    if (w >= 400) summarize();
  endtask

  // Follows one thread over n own cycles; the cycles between belong to the other.
  task automatic trace(input logic sel, input int n, input logic other_valid,
                       input logic [7:0] acc_other, input logic [7:0] sp_exp, input int hits);
    int w;
    int h;
    w = 0;
    h = 0;
    while (!(owner_o === sel && fetch_valid_o === 1'b1) && w < 300) begin
      @(negedge clock_i);
      w++;
    end
    if (w >= 300) begin
      check("thread start", 12'h001, 12'h000);
      summarize();
    end
    for (int i = 0; i < 2 * n; i++) begin
      if (i > 0) @(negedge clock_i);
      if (i % 2 == 0) begin
        check("owner", {11'h000, sel}, {11'h000, owner_o});
        check("step", 12'h001, {11'h000, fetch_valid_o});
        check("fetch", exp_ip[i / 2], fetch_addr_o);
        if (stack_valid_o === 1'b1) begin
          h++;
          check("stack addr", {4'h0, sp_exp}, {4'h0, stack_addr_o});
        end
      end else begin
        check("other owner", {11'h000, ~sel}, {11'h000, owner_o});
        check("other step", {11'h000, other_valid}, {11'h000, fetch_valid_o});
        check("other acc", {4'h0, acc_other}, {4'h0, acc_o});
      end
    end
    check("stack uses", hits[11:0], h[11:0]);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------------
  // Reset values, stack pointer write before boot, and an unmapped address.
  task automatic t_regs();
    reg_read(8'h10, 8'h01);
    reg_read(8'h02, 8'h00);
    reg_write(8'h02, 8'h30);
    reg_read(8'h02, 8'h30);
    reg_write(8'h44, 8'hff);
    reg_read(8'h44, 8'h00);
    $display("test regs done");
  endtask

  // Thread 0 alone: jump, accumulator write, call and return; thread 1 held at one.
  task automatic t_thread0();
    wait_boot();
    exp_ip = '{12'h000, 12'h020, 12'h021, 12'h040, 12'h022, 12'h022, 12'h022, 12'h022};
    trace(1'b0, 6, 1'b0, 8'h00, 8'h30, 2);
    @(negedge clock_i);
    check("acc", 12'h05a, {4'h0, acc_o});
    check("flags", 12'h00a, {8'h00, flag_o});
    $display("test thread0 done");
  endtask

  // Software turns thread 1 on; it starts at one and keeps its own stack pointer.
  task automatic t_thread1();
    reg_write(8'h10, 8'h03);
    @(negedge clock_i);
    exp_ip = '{12'h001, 12'h002, 12'h003, 12'h004, 12'h050, 12'h005, 12'h006, 12'h007};
    trace(1'b1, 8, 1'b1, 8'h5a, 8'h00, 2);
    reg_read(8'h10, 8'h03);
    $display("test thread1 done");
  endtask

  // Thread 1 switched off again, then an interrupt sends thread 0 to its entry.
  task automatic t_irq();
    reg_write(8'h10, 8'h01);
    @(posedge clock_i);
    irq_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    irq_i <= 1'b0;
    @(negedge clock_i);
    exp_ip = '{12'h010, 12'h011, 12'h012, 12'h013, 12'h000, 12'h000, 12'h000, 12'h000};
    trace(1'b0, 4, 1'b0, 8'h00, 8'h00, 0);
    $display("test irq done");
  endtask

  // Single-thread option keeps thread 1 off; thread 0 then writes its stack pointer by IO.
  task automatic t_single();
    @(posedge clock_i);
    do_reset(1'b1);
    reg_write(8'h10, 8'h03);
    reg_read(8'h12, 8'h01);
    wait_boot();
    exp_ip = '{12'h000, 12'h020, 12'h021, 12'h040, 12'h022, 12'h022, 12'h022, 12'h022};
    trace(1'b0, 8, 1'b0, 8'h00, 8'h00, 2);
    @(posedge clock_i);
    io_we_i <= 1'b1;
    reg_addr_i <= 8'h02;
    reg_wdata_i <= 8'h44;
    repeat (2) @(posedge clock_i);
    io_we_i <= 1'b0;
    @(negedge clock_i);
    if (owner_o !== 1'b0) @(negedge clock_i);
    check("io sp own", 12'h044, {4'h0, stack_addr_o});
    @(negedge clock_i);
    check("io sp other", 12'h000, {4'h0, stack_addr_o});
    $display("test single done");
  endtask

  // Main sequence; every path ends in the closing report.
  initial begin
    do_reset(1'b0);
    t_regs();
    t_thread0();
    t_thread1();
    t_irq();
    t_single();
    summarize();
  end
endmodule
